// [design/kbc_host_port.sv]
// Host I/O port side of the keyboard/mouse controller: status, data, commands.
// Assumes the host I/O bus is decoded to one-cycle read/write strobes on ref_clk.
// Functional notes
// R1 - Reading the command port returns the status byte.
// R2 - Every command port write is treated as a command code.
// R3 - Data bytes move in both directions only through the data port.
// R4 - Command 60h then a data byte loads the control byte.
// R5 - Command 20h puts control byte in output buffer and sets full flag.
// R6 - Port pins are open-collector; a high bit releases the pin.
// R7 - Input port bits 0-5 driven low by B0-B3,B6,B7, high by B8-BB,BE,BF.
// R8 - Output bits 2,3 driven low by B4,B5 and high by BC,BD.
// R9 - Output bit 0 requests system reset; bit 1 enables upper address gate.
// R10 - Output bit 4 drives keyboard full interrupt, bit 5 mouse interrupt.
// R11 - Output bit 6 drives keyboard clock, bit 7 keyboard data.
// R12 - Test port bit 0 is keyboard clock, bit 1 mouse clock.
// R13 - Command C0h copies input port into the output buffer.
// R14 - Command D0h copies output port into the output buffer.
// R15 - Command E0h copies test port into the output buffer.
// R16 - Host writes data port only while input buffer full reads 0.
// R17 - Host reads data port only while output buffer full reads 1.
// R18 - Data port read returns output buffer; host cannot write it.
// R19 - Status bit 0 shows output buffer holds a byte; resets empty.
// R20 - Status bit 1 shows a host byte is pending; resets empty.
// R21 - A status bit records whether last write was data or command.
// R22 - Reading data clears output full; consuming a byte clears input full.
// R23 - Any host write to either port sets input full.
module kbc_host_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Host I/O access
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_ack,
  output logic wr_full,
  // Input port pins, open-collector
  input wire logic [7:0] in_port_i,
  output logic [7:0] in_port_o,
  output logic [7:0] in_port_oe_n,
  // Output port pins, open-collector
  input wire logic [7:0] out_port_i,
  output logic [7:0] out_port_o,
  output logic [7:0] out_port_oe_n,
  // Test inputs
  input wire logic kbd_clock_sense,
  input wire logic aux_clock_sense,
  // System outputs
  output logic system_reset_request,
  output logic upper_address_gate,
  output logic kbd_full_irq,
  output logic aux_full_irq,
  output logic [7:0] control_byte
);
  typedef struct packed {
    kbc_pkg::kbc_state_e state;
    logic [7:0] cmd;
    logic is_data;
    logic [7:0] ctrl;
    logic [7:0] outp;
    logic [5:0] in_drv;
    logic [7:0] obuf;
    logic output_full_flag;
    logic last_cmd;
    logic [7:0] rdata;
    logic [2:0][7:0] in_sync;
    logic [2:0][1:0] t_sync;
    logic [7:0] in_q;
    logic [1:0] t_q;
  } kbc_state_s;

  kbc_state_s st_r, st_nxt;
  logic wr_acc;
  logic ibf;
  logic [3:0] pin_sel;

  kbc_fifo_if #(.W(kbc_pkg::FIFO_W)) wr_in ();
  kbc_fifo_if #(.W(kbc_pkg::FIFO_W)) wr_out ();

  // Map a B0-BF code onto the port bit it touches; bit 3 flags output port
  function automatic logic [3:0] pin_of(input logic [2:0] low);
    case (low)
      3'h0: pin_of = 4'h0;
      3'h1: pin_of = 4'h1;
      3'h2: pin_of = 4'h2;
      3'h3: pin_of = 4'h3;
      3'h4: pin_of = 4'h8 | 4'h2;
      3'h5: pin_of = 4'h8 | 4'h3;
      3'h6: pin_of = 4'h4;
      default: pin_of = 4'h5;
    endcase
  endfunction

  // Decoded once so the bit tests below select from a plain vector
  assign pin_sel = pin_of(st_r.cmd[2:0]);

  // Writes go through the FIFO; while it is full wr_full is set and further host writes are dropped
  assign wr_acc = io_wr && (io_addr == kbc_pkg::DATA_PORT || io_addr == kbc_pkg::CMD_PORT);
  assign wr_in.valid = wr_acc;
  assign wr_in.data = {io_addr == kbc_pkg::DATA_PORT, io_wdata};
  assign wr_full = !wr_in.ready;
  assign ibf = wr_out.valid || st_r.state == kbc_pkg::ST_EXEC; // R20 R22 R23
  assign wr_out.ready = (st_r.state != kbc_pkg::ST_EXEC);

  kbc_fifo #(.W(kbc_pkg::FIFO_W), .D(kbc_pkg::FIFO_D)) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_s(wr_in),
    .out_s(wr_out)
  );

  always_comb begin
    st_nxt = st_r;
    // Three-stage sampling; change accepted once stages two and three agree
    st_nxt.in_sync = {st_r.in_sync[1:0], in_port_i};
    st_nxt.t_sync = {st_r.t_sync[1:0], {aux_clock_sense, kbd_clock_sense}};
    if (st_r.in_sync[1] == st_r.in_sync[2]) st_nxt.in_q = st_r.in_sync[2];
    if (st_r.t_sync[1] == st_r.t_sync[2]) st_nxt.t_q = st_r.t_sync[2];

    // Host read: status at command port, output buffer at data port
    st_nxt.rdata = 8'h00;
    if (io_rd && io_addr == kbc_pkg::CMD_PORT) begin
      st_nxt.rdata[kbc_pkg::ST_OBF] = st_r.output_full_flag; // R1 R19
      st_nxt.rdata[kbc_pkg::ST_IBF] = ibf; // R20
      st_nxt.rdata[kbc_pkg::ST_SYSF] = 1'b1;
      st_nxt.rdata[kbc_pkg::ST_CMD] = st_r.last_cmd; // R21
    end else if (io_rd && io_addr == kbc_pkg::DATA_PORT) begin
      st_nxt.rdata = st_r.obuf; // R3 R18
      st_nxt.output_full_flag = 1'b0; // R22
    end
    if (wr_acc && wr_in.ready)
      st_nxt.last_cmd = (io_addr == kbc_pkg::CMD_PORT); // R21

    case (st_r.state)
      kbc_pkg::ST_IDLE,
      kbc_pkg::ST_WAIT_DATA: begin
        if (wr_out.valid) begin
          st_nxt.cmd = wr_out.data[7:0];
          st_nxt.is_data = wr_out.data[8];
          st_nxt.state = kbc_pkg::ST_EXEC;
          if (wr_out.data[8] && st_r.state != kbc_pkg::ST_WAIT_DATA) st_nxt.state = kbc_pkg::ST_IDLE;
        end
      end
      kbc_pkg::ST_EXEC: begin
        st_nxt.state = kbc_pkg::ST_IDLE;
        if (st_r.is_data) begin
          st_nxt.ctrl = st_r.cmd; // R4
        end else begin
          // R2
          case (st_r.cmd)
            kbc_pkg::CMD_WR_CTRL: st_nxt.state = kbc_pkg::ST_WAIT_DATA; // R4
            kbc_pkg::CMD_RD_CTRL: begin
              st_nxt.obuf = st_r.ctrl; // R5
              st_nxt.output_full_flag = 1'b1; // R5
            end
            kbc_pkg::CMD_RD_IN: begin
              st_nxt.obuf = st_r.in_q; // R13
              st_nxt.output_full_flag = 1'b1;
            end
            kbc_pkg::CMD_RD_OUT: begin
              st_nxt.obuf = st_r.outp; // R14
              st_nxt.output_full_flag = 1'b1;
            end
            kbc_pkg::CMD_RD_TEST: begin
              st_nxt.obuf = {6'h00, st_r.t_q}; // R12 R15
              st_nxt.output_full_flag = 1'b1;
            end
            default: begin
              if (st_r.cmd[7:4] == kbc_pkg::CMD_LO_BASE[7:4]) begin
                if (pin_sel[3])
                  st_nxt.outp[pin_sel[2:0]] = st_r.cmd[3]; // R8
                else
                  st_nxt.in_drv[pin_sel[2:0]] = st_r.cmd[3]; // R7
              end
            end
          endcase
        end
      end
      default: st_nxt.state = kbc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.state <= kbc_pkg::ST_IDLE;
      st_r.ctrl <= kbc_pkg::CTRL_RST;
      st_r.outp <= kbc_pkg::OUTP_RST;
      st_r.in_drv <= kbc_pkg::INP_DRV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io_rdata = st_r.rdata;
  assign io_ack = 1'b1;
  assign control_byte = st_r.ctrl;
  // Open-collector: a one releases the pin, a zero pulls it low
  assign in_port_o = 8'h00;
  assign in_port_oe_n = {2'b11, st_r.in_drv}; // R6
  assign out_port_o = 8'h00;
  assign out_port_oe_n = st_r.outp; // R6 R11
  assign system_reset_request = st_r.outp[kbc_pkg::OP_RST]; // R9
  assign upper_address_gate = st_r.outp[kbc_pkg::OP_GATE]; // R9
  assign kbd_full_irq = st_r.outp[kbc_pkg::OP_KBD_IRQ]; // R10
  assign aux_full_irq = st_r.outp[kbc_pkg::OP_AUX_IRQ]; // R10

  rd_ctrl_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R5
    st_r.state == kbc_pkg::ST_EXEC && !st_r.is_data && st_r.cmd == kbc_pkg::CMD_RD_CTRL
    |=> st_r.output_full_flag && st_r.obuf == $past(st_r.ctrl)) else $error("read control not buffered");
  wr_ctrl_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
    st_r.state == kbc_pkg::ST_EXEC && st_r.is_data |=> st_r.ctrl == $past(st_r.cmd))
    else $error("control byte not loaded");
  obf_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R22
    io_rd && io_addr == kbc_pkg::DATA_PORT && !(st_r.state == kbc_pkg::ST_EXEC)
    |=> !st_r.output_full_flag) else $error("output full not cleared");
  status_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
    io_rd && io_addr == kbc_pkg::CMD_PORT |=> io_rdata[kbc_pkg::ST_OBF] == $past(st_r.output_full_flag))
    else $error("status read wrong");
  data_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R18
    io_rd && io_addr == kbc_pkg::DATA_PORT |=> io_rdata == $past(st_r.obuf))
    else $error("data read wrong");
  ibf_set_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R23
    wr_acc && wr_in.ready |=> ibf) else $error("input full not set");
  in_copy_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R13
    st_r.state == kbc_pkg::ST_EXEC && !st_r.is_data && st_r.cmd == kbc_pkg::CMD_RD_IN
    |=> st_r.obuf == $past(st_r.in_q)) else $error("input port not copied");
  out_copy_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R14
    st_r.state == kbc_pkg::ST_EXEC && !st_r.is_data && st_r.cmd == kbc_pkg::CMD_RD_OUT
    |=> st_r.obuf == $past(st_r.outp)) else $error("output port not copied");
  pin_low_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R8
    st_r.state == kbc_pkg::ST_EXEC && !st_r.is_data && st_r.cmd == 8'hB4
    |=> !out_port_oe_n[kbc_pkg::OP_AUX_DATA]) else $error("mouse data not driven low");
  cmd_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R21
    wr_acc && wr_in.ready |=> st_r.last_cmd == ($past(io_addr) == kbc_pkg::CMD_PORT))
    else $error("command flag wrong");

  // Pin commands, both directions on both ports
  pin_high_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R8
    st_r.state == kbc_pkg::ST_EXEC && !st_r.is_data && st_r.cmd == 8'hBC
    |=> out_port_oe_n[kbc_pkg::OP_AUX_DATA]) else $error("mouse data not released");

  aux_clk_low_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R8
    st_r.state == kbc_pkg::ST_EXEC && !st_r.is_data && st_r.cmd == 8'hB5
    |=> !out_port_oe_n[kbc_pkg::OP_AUX_CLK]) else $error("mouse clock not driven low");

  in_low_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R7
    st_r.state == kbc_pkg::ST_EXEC && !st_r.is_data && st_r.cmd == 8'hB7
    |=> !in_port_oe_n[5]) else $error("input bit five not driven low");

  in_high_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R7
    st_r.state == kbc_pkg::ST_EXEC && !st_r.is_data && st_r.cmd == 8'hB8
    |=> in_port_oe_n[0]) else $error("input bit zero not released");

  in_top_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R7
    st_r.state == kbc_pkg::ST_EXEC && !st_r.is_data
    |=> in_port_oe_n[7:6] == 2'b11) else $error("input bits six and seven driven");

  // Buffer copies and the pending control write
  test_copy_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R15
    st_r.state == kbc_pkg::ST_EXEC && !st_r.is_data && st_r.cmd == kbc_pkg::CMD_RD_TEST
    |=> st_r.output_full_flag && st_r.obuf == {6'h00, $past(st_r.t_q)}) else $error("test port not copied");

  wait_data_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
    st_r.state == kbc_pkg::ST_EXEC && !st_r.is_data && st_r.cmd == kbc_pkg::CMD_WR_CTRL
    |=> st_r.state == kbc_pkg::ST_WAIT_DATA) else $error("control write not armed");

  // A stray data byte must not reach the control byte
  data_drop_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
    st_r.state == kbc_pkg::ST_IDLE && wr_out.valid && wr_out.data[8]
    |=> st_r.state == kbc_pkg::ST_IDLE && st_r.ctrl == $past(st_r.ctrl))
    else $error("stray data byte used");

  // Host read port
  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
    !io_rd |=> io_rdata == 8'h00) else $error("read data without read");

  status_ibf_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R20
    io_rd && io_addr == kbc_pkg::CMD_PORT |=> io_rdata[kbc_pkg::ST_IBF] == $past(ibf))
    else $error("pending flag read wrong");

  status_cmd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R21
    io_rd && io_addr == kbc_pkg::CMD_PORT |=> io_rdata[kbc_pkg::ST_CMD] == $past(st_r.last_cmd))
    else $error("command flag read wrong");

  // A dropped write leaves the command flag alone
  wr_drop_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R21
    wr_acc && !wr_in.ready |=> st_r.last_cmd == $past(st_r.last_cmd))
    else $error("dropped write changed flag");

  // System outputs follow the output port byte
  sys_outs_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R9
    system_reset_request == out_port_oe_n[kbc_pkg::OP_RST]
    && upper_address_gate == out_port_oe_n[kbc_pkg::OP_GATE]) else $error("system outputs wrong");
endmodule

// [common/kbc_pkg.sv]
// Constants and state type for the keyboard/mouse controller host port block.
// Assumes a single ref_clk domain and synchronous active-low reset.
package kbc_pkg;
  localparam logic [7:0] DATA_PORT = 8'h60;
  localparam logic [7:0] CMD_PORT = 8'h64;
  // Status byte fields
  localparam int ST_OBF = 0;
  localparam int ST_IBF = 1;
  localparam int ST_SYSF = 2;
  localparam int ST_CMD = 3;
  // Command codes
  localparam logic [7:0] CMD_RD_CTRL = 8'h20;
  localparam logic [7:0] CMD_WR_CTRL = 8'h60;
  localparam logic [7:0] CMD_RD_IN = 8'hC0;
  localparam logic [7:0] CMD_RD_OUT = 8'hD0;
  localparam logic [7:0] CMD_RD_TEST = 8'hE0;
  localparam logic [7:0] CMD_LO_BASE = 8'hB0;
  localparam logic [7:0] CMD_HI_BASE = 8'hB8;
  // Output port bits
  localparam int OP_RST = 0;
  localparam int OP_GATE = 1;
  localparam int OP_AUX_DATA = 2;
  localparam int OP_AUX_CLK = 3;
  localparam int OP_KBD_IRQ = 4;
  localparam int OP_AUX_IRQ = 5;
  localparam int OP_KBD_CLK = 6;
  localparam int OP_KBD_DATA = 7;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OUTP_RST = 8'hFC;
  localparam logic [5:0] INP_DRV_RST = 6'h3F;
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 16;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT_DATA} kbc_state_e;
endpackage

// [common/kbc_fifo_if.sv]
// Valid/ready stream carrying host writes into the command interpreter.
// Assumes both ends share ref_clk.
interface kbc_fifo_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// [design/kbc_fifo.sv]
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-low reset.
module kbc_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Streams
  kbc_fifo_if.dst in_s,
  kbc_fifo_if.src out_s
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } kbc_fifo_s;
  kbc_fifo_s st_r, st_nxt;
  logic [W-1:0] mem_r [D];
  logic push, pop;

  assign in_s.ready = (st_r.cnt != (AW+1)'(D));
  assign out_s.valid = (st_r.cnt != '0);
  assign out_s.data = mem_r[st_r.rp];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    st_nxt = st_r;
    if (push) st_nxt.wp = st_r.wp + 1'b1;
    if (pop) st_nxt.rp = st_r.rp + 1'b1;
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) st_r <= '0;
    else st_r <= st_nxt;
    if (push) mem_r[st_r.wp] <= in_s.data;
  end

  fifo_bound_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_r.cnt <= (AW+1)'(D)) else $error("fifo count above depth");
endmodule

// [test/kbc_host_model.sv]
// Host processor model: byte reads and writes at the data and command ports.
// Assumes one-cycle strobes taken on ref_clk and read data one cycle later.
module kbc_host_model (
  // Clock
  input wire logic ref_clk,
  // I/O bus
  input wire logic [7:0] io_rdata,
  input wire logic wr_full,
  output logic [7:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    io_addr = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge ref_clk);
    io_rd <= 1'b0;
    #1;
    d = io_rdata;
  endtask

  // Polls the pending flag first; bounded so a stuck flag cannot hang us
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] s;
    s = 8'h02;
    for (int i = 0; i < 50 && s[1]; i++) rd(8'h64, s);
    @(posedge ref_clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge ref_clk);
    io_wr <= 1'b0;
  endtask

  task automatic rd_data(output logic [7:0] d);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 50 && !s[0]; i++) rd(8'h64, s);
    rd(8'h60, d);
  endtask

  // Ignored command every cycle, faster than the interpreter drains
  task automatic burst(input int n, output logic seen_full);
    seen_full = 1'b0;
    @(posedge ref_clk);
    io_wr <= 1'b1;
    io_addr <= 8'h64;
    io_wdata <= 8'h00;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      seen_full = seen_full | wr_full;
    end
    @(posedge ref_clk);
    io_wr <= 1'b0;
  endtask
endmodule

// [test/kbc_host_port_tb.sv]
// Self-checking bench for the controller host port block.
// Assumes the host model drives the I/O bus; port pins are pulled up.
module kbc_host_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, nrst, io_wr, io_rd, io_ack, wr_full, kbd_clock_sense, aux_clock_sense;
  logic [7:0] io_addr, io_wdata, io_rdata, in_port_i, in_port_oe_n, out_port_i, out_port_oe_n, control_byte;
  logic system_reset_request, upper_address_gate, kbd_full_irq, aux_full_irq;
  int num_errors = 0;
  int num_checks = 0;

  // Open-collector pins with pull-ups and nothing else pulling
  assign in_port_i = in_port_oe_n;
  assign out_port_i = out_port_oe_n;

  kbc_host_model i_host (.ref_clk(ref_clk), .io_rdata(io_rdata), .wr_full(wr_full), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
  kbc_host_port i_dut (.ref_clk(ref_clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack), .wr_full(wr_full), .in_port_i(in_port_i),
    .in_port_o(), .in_port_oe_n(in_port_oe_n), .out_port_i(out_port_i), .out_port_o(),
    .out_port_oe_n(out_port_oe_n), .kbd_clock_sense(kbd_clock_sense), .aux_clock_sense(aux_clock_sense),
    .system_reset_request(system_reset_request), .upper_address_gate(upper_address_gate),
    .kbd_full_irq(kbd_full_irq), .aux_full_irq(aux_full_irq), .control_byte(control_byte));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    i_host.wr(8'h64, c);
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset;
    logic [7:0] s;
    i_host.rd(8'h64, s);
    chk("status", 8'h00, s & 8'h03);
    chk("sys outs", 8'h30, {2'b00, aux_full_irq, kbd_full_irq, 2'b00, upper_address_gate, system_reset_request});
    chk("out port", 8'hFC, out_port_oe_n);
    chk("in port", 8'hFF, in_port_oe_n);
    chk("control", 8'h00, control_byte);
    chk("ack", 8'h01, {7'h00, io_ack});
    i_host.rd(8'h61, s);
    chk("unmapped", 8'h00, s);
  endtask

  task automatic t_ctrl;
    logic [7:0] s, d;
    i_host.wr(8'h64, 8'h60);
    i_host.wr(8'h60, 8'hA5);
    i_host.rd(8'h64, s);
    chk("data flag", 8'h00, s & 8'h08);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("control", 8'hA5, control_byte);
    i_host.wr(8'h60, 8'h20);
    i_host.wr(8'h64, 8'h20);
    i_host.rd(8'h64, s);
    chk("cmd flag", 8'h08, s & 8'h08);
    i_host.wr(8'h60, 8'h11);
    i_host.rd_data(d);
    chk("control read", 8'hA5, d);
    i_host.rd(8'h64, s);
    chk("full clear", 8'h00, s & 8'h01);
  endtask

  task automatic t_pins;
    logic [7:0] lo [6] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB6, 8'hB7};
    logic [7:0] e, d;
    for (int b = 0; b < 6; b++) begin
      cmd(lo[b]);
      e = 8'hFF;
      e[b] = 1'b0;
      chk("in pins", e, in_port_oe_n);
      i_host.wr(8'h64, 8'hC0);
      i_host.rd_data(d);
      chk("in copy", e, d);
      cmd(lo[b] + 8'h08);
      chk("in pins", 8'hFF, in_port_oe_n);
    end
    for (int b = 2; b < 4; b++) begin
      cmd(8'hB2 + b[7:0]);
      e = 8'hFC;
      e[b] = 1'b0;
      chk("out pins", e, out_port_oe_n);
      i_host.wr(8'h64, 8'hD0);
      i_host.rd_data(d);
      chk("out copy", e, d);
      cmd(8'hBA + b[7:0]);
      chk("out pins", 8'hFC, out_port_oe_n);
    end
  endtask

  task automatic t_test;
    logic [7:0] d;
    for (int k = 1; k < 3; k++) begin
      @(posedge ref_clk);
      kbd_clock_sense <= k[0];
      aux_clock_sense <= k[1];
      i_host.wr(8'h64, 8'hE0);
      i_host.rd_data(d);
      chk("test port", {6'h00, k[1:0]}, d & 8'h03);
    end
  endtask

  task automatic t_burst;
    logic f;
    logic [7:0] s;
    i_host.burst(40, f);
    chk("fifo full", 8'h01, {7'h00, f});
    i_host.rd(8'h64, s);
    chk("pending set", 8'h02, s & 8'h02);
    for (int i = 0; i < 100 && s[1]; i++) i_host.rd(8'h64, s);
    chk("pending clear", 8'h00, s & 8'h02);
  endtask

  task automatic end_sim;
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Whole run needs a few hundred cycles
  initial begin
    #200us;
    num_errors++;
    end_sim;
  end

  initial begin
    nrst = 1'b0;
    kbd_clock_sense = 1'b0;
    aux_clock_sense = 1'b0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset;
    t_ctrl;
    t_pins;
    t_test;
    t_burst;
    end_sim;
  end
endmodule
